// *** logic/plc_pkg.sv ***
package plc_pkg;
  // Register byte offsets.
  localparam logic [4:0] MASTER_OFS = 5'h00;
  localparam logic [4:0] LOCK_OFS = 5'h04;
  localparam logic [4:0] CAL_OFS = 5'h08;
  localparam logic [4:0] FAST_OFS = 5'h0C;
  localparam logic [4:0] STATUS_OFS = 5'h10;
  // Master register fields.
  localparam int INHIBIT_BIT = 26;
  localparam int PUMP_LSB = 21;
  localparam int NINT_LSB = 0;
  localparam int NINT_W = 17;
  // Lock control register fields.
  localparam int POL_BIT = 0;
  localparam int WIN_LSB = 1;
  localparam int CNT_LSB = 4;
  localparam int AMP_LSB = 7;
  localparam int MUTE_BIT = 10;
  localparam int PD1_BIT = 11;
  localparam int PD2_BIT = 12;
  // Calibration control register fields.
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 10;
  localparam int RECAL_BIT = 10;
  // Fast-lock register fields.
  localparam int FL_LSB = 0;
  localparam int FL_W = 13;
  localparam int FLEN_BIT = 13;
  localparam int FLPUMP_LSB = 14;
  // Reset values.
  localparam logic [4:0] PUMP_RST = 5'h10;
  localparam logic [2:0] AMP_RST = 3'h4;
  localparam logic [DIV_W-1:0] DIV_RST = 10'h001;
  localparam logic [4:0] FLPUMP_RST = 5'h1F;
  localparam logic [2:0] WIN_RST = 3'h7;
  localparam logic [2:0] CNT_RST = 3'h2;
  // Lock detector: window step and spacing code saturation, in ns.
  localparam int WIN_STEP_NS = 2;
  localparam logic [4:0] SPACING_SAT = 5'h1F;
  localparam logic [12:0] LOCK_CNT_BASE = 13'h0004;
  localparam logic [4:0] PUMP_MAX = 5'h1F;
  // Calibration sequence length in calibrator clock ticks.
  localparam int CAL_BITS = 8;
  localparam logic [3:0] CAL_STEPS = 4'hD;
  // Pin synchroniser indices.
  localparam int PIN_CMP = 0;
  localparam int PIN_UP = 1;
  localparam int PIN_DN = 2;
  localparam int PIN_PD1 = 3;
  localparam int PIN_PD2 = 4;
  localparam int PIN_FAST = 5;
  localparam int PIN_N = 6;
  typedef enum logic [1:0] {CAL_IDLE, CAL_PRECHARGE, CAL_SEARCH, CAL_SETTLE} plc_cal_state_t;
endpackage

// *** logic/plc_supervisor.sv ***
// Behaviour
// - lock decision compares up and down phase detector edges each compare cycle.
// - lock output polarity flips when lock_polarity_invert is set.
// - in-window means edge spacing below 2 to 16 ns threshold from 3-bit select.
// - lock declared after 4 to 4096 consecutive in-window cycles, 3-bit select.
// - nominal pump current chosen from 32 levels by 5-bit code.
// - code zero gives no current; each step about 158 uA up to all-ones.
// - fast lock holds wide band with raised current for 13-bit cycle count.
// - cycle slips raise pump current until locking ends, then programmed value returns.
// - a master register write starts oscillator and sub-band search on calibrator clock unless it writes bit 26 as one.
// - the search completes in about 13 calibrator clock cycles.
// - calibrator clock is compare clock over divide ratio; software keeps it legal.
// - oscillator amplitude set by a 3-bit field.
// - with recal enabled, a lock falling edge restarts calibration.
// - each output powers down on software bit or its hardware pin.
// - with mute enabled, outputs stay off until lock is reported.
// - master bit 26 suppresses the calibration the write would start; reads as one.
`timescale 1ns/1ps
`default_nettype none
module plc_supervisor (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Phase detector and oscillator pins.
  input wire logic cmp_clk_pin,
  input wire logic pfd_up_pin,
  input wire logic pfd_dn_pin,
  input wire logic [4:0] pfd_edge_spacing,
  input wire logic osc_too_fast_pin,
  // Hardware power-down pins.
  input wire logic primary_output_powerdown_pin,
  input wire logic secondary_output_powerdown_pin,
  // Analog controls and status.
  output logic lock_out,
  output logic [4:0] pump_current_code,
  output logic wide_band_mode,
  output logic [2:0] oscillator_amplitude,
  output logic tune_hold,
  output logic [1:0] osc_sel,
  output logic [5:0] subband,
  output logic primary_output_off,
  output logic secondary_output_off
);
  logic [plc_pkg::PIN_N-1:0] pin_s1_q;
  logic [plc_pkg::PIN_N-1:0] pin_s2_q;
  logic [plc_pkg::PIN_N-1:0] pin_s3_q;
  logic [plc_pkg::PIN_N-1:0] pin_q;
  logic [plc_pkg::PIN_N-1:0] pin_raw;
  logic cmp_prev_q;
  logic cmp_edge;
  logic [4:0] spacing_q;
  logic [16:0] nint_q;
  logic [4:0] pump_q;
  logic pol_q;
  logic [2:0] win_q;
  logic [2:0] cnt_sel_q;
  logic [2:0] amp_q;
  logic mute_q;
  logic pd1_q;
  logic pd2_q;
  logic [9:0] div_q;
  logic recal_q;
  logic [12:0] fl_len_q;
  logic fl_en_q;
  logic [4:0] fl_pump_q;
  logic [31:0] rd_word;
  logic [31:0] be_mask;
  logic [31:0] wr_word;
  logic acc_done;
  logic mst_wr;
  logic [12:0] lock_cnt_q;
  logic [12:0] lock_target;
  logic in_window;
  logic lock_q;
  logic lock_prev_q;
  logic [12:0] fl_cnt_q;
  logic slip_q;
  logic [9:0] div_cnt_q;
  logic cal_tick;
  logic cal_start;
  logic cal_busy;

  assign pin_raw = {osc_too_fast_pin, secondary_output_powerdown_pin,
                    primary_output_powerdown_pin, pfd_dn_pin, pfd_up_pin, cmp_clk_pin};

  // Three-stage synchronisers; a change is taken once stages two and three agree.
  for (genvar i = 0; i < plc_pkg::PIN_N; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
        pin_s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // The spacing code is held stable by the detector across each compare edge.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cmp_prev_q <= 1'b0;
      spacing_q <= plc_pkg::SPACING_SAT;
    end else begin
      cmp_prev_q <= pin_q[plc_pkg::PIN_CMP];
      spacing_q <= pfd_edge_spacing;
    end
  end
  assign cmp_edge = pin_q[plc_pkg::PIN_CMP] && !cmp_prev_q;

  // Register bus.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      plc_pkg::MASTER_OFS: begin
        rd_word[plc_pkg::INHIBIT_BIT] = 1'b1;
        rd_word[plc_pkg::PUMP_LSB +: 5] = pump_q;
        rd_word[plc_pkg::NINT_LSB +: plc_pkg::NINT_W] = nint_q;
      end
      plc_pkg::LOCK_OFS: begin
        rd_word[plc_pkg::POL_BIT] = pol_q;
        rd_word[plc_pkg::WIN_LSB +: 3] = win_q;
        rd_word[plc_pkg::CNT_LSB +: 3] = cnt_sel_q;
        rd_word[plc_pkg::AMP_LSB +: 3] = amp_q;
        rd_word[plc_pkg::MUTE_BIT] = mute_q;
        rd_word[plc_pkg::PD1_BIT] = pd1_q;
        rd_word[plc_pkg::PD2_BIT] = pd2_q;
      end
      plc_pkg::CAL_OFS: begin
        rd_word[plc_pkg::DIV_LSB +: plc_pkg::DIV_W] = div_q;
        rd_word[plc_pkg::RECAL_BIT] = recal_q;
      end
      plc_pkg::FAST_OFS: begin
        rd_word[plc_pkg::FL_LSB +: plc_pkg::FL_W] = fl_len_q;
        rd_word[plc_pkg::FLEN_BIT] = fl_en_q;
        rd_word[plc_pkg::FLPUMP_LSB +: 5] = fl_pump_q;
      end
      plc_pkg::STATUS_OFS: begin
        // From the top: tune hold, busy, sub-band, oscillator, slip, wide band, pump, lock.
        rd_word[17:0] = {tune_hold, cal_busy, subband, osc_sel, slip_q,
                         wide_band_mode, pump_current_code, lock_q};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
  end
  assign wr_word = (rd_word & ~be_mask) | (avs_writedata & be_mask);
  assign acc_done = !avs_waitrequest && (avs_read || avs_write);
  assign mst_wr = acc_done && avs_write && (avs_address == plc_pkg::MASTER_OFS);

  // Requests are accepted on the second edge after they appear, after one wait cycle; read data is ready then.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= rd_word;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      nint_q <= 17'h0_0000;
      pump_q <= plc_pkg::PUMP_RST;
      pol_q <= 1'b0;
      win_q <= plc_pkg::WIN_RST;
      cnt_sel_q <= plc_pkg::CNT_RST;
      amp_q <= plc_pkg::AMP_RST;
      mute_q <= 1'b0;
      pd1_q <= 1'b0;
      pd2_q <= 1'b1;
      div_q <= plc_pkg::DIV_RST;
      recal_q <= 1'b0;
      fl_len_q <= 13'h0000;
      fl_en_q <= 1'b0;
      fl_pump_q <= plc_pkg::FLPUMP_RST;
    end else if (acc_done && avs_write) begin
      case (avs_address)
        plc_pkg::MASTER_OFS: begin
          pump_q <= wr_word[plc_pkg::PUMP_LSB +: 5];
          nint_q <= wr_word[plc_pkg::NINT_LSB +: plc_pkg::NINT_W];
        end
        plc_pkg::LOCK_OFS: begin
          pol_q <= wr_word[plc_pkg::POL_BIT];
          win_q <= wr_word[plc_pkg::WIN_LSB +: 3];
          cnt_sel_q <= wr_word[plc_pkg::CNT_LSB +: 3];
          amp_q <= wr_word[plc_pkg::AMP_LSB +: 3];
          mute_q <= wr_word[plc_pkg::MUTE_BIT];
          pd1_q <= wr_word[plc_pkg::PD1_BIT];
          pd2_q <= wr_word[plc_pkg::PD2_BIT];
        end
        plc_pkg::CAL_OFS: begin
          div_q <= wr_word[plc_pkg::DIV_LSB +: plc_pkg::DIV_W];
          recal_q <= wr_word[plc_pkg::RECAL_BIT];
        end
        plc_pkg::FAST_OFS: begin
          fl_len_q <= wr_word[plc_pkg::FL_LSB +: plc_pkg::FL_W];
          fl_en_q <= wr_word[plc_pkg::FLEN_BIT];
          fl_pump_q <= wr_word[plc_pkg::FLPUMP_LSB +: 5];
        end
        default: begin
        end
      endcase
    end
  end

  // Lock detector.
  assign in_window = ({3'h0, spacing_q} <
                      8'((32'(win_q) + 1) * plc_pkg::WIN_STEP_NS));
  always_comb begin
    case (cnt_sel_q)
      3'h5: lock_target = plc_pkg::LOCK_CNT_BASE << 6;
      3'h6: lock_target = plc_pkg::LOCK_CNT_BASE << 8;
      3'h7: lock_target = plc_pkg::LOCK_CNT_BASE << 10;
      default: lock_target = plc_pkg::LOCK_CNT_BASE << cnt_sel_q;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lock_cnt_q <= 13'h0000;
      lock_q <= 1'b0;
    end else if (cmp_edge) begin
      if (!in_window) begin
        lock_cnt_q <= 13'h0000;
        lock_q <= 1'b0;
      end else if (lock_cnt_q != lock_target) begin
        lock_cnt_q <= lock_cnt_q + 13'h0001;
        lock_q <= (lock_cnt_q + 13'h0001 == lock_target);
      end
    end
  end

  // Fast lock window, counted in compare cycles from each master register write.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fl_cnt_q <= 13'h0000;
    end else if (mst_wr) begin
      fl_cnt_q <= fl_en_q ? fl_len_q : 13'h0000;
    end else if (cmp_edge && fl_cnt_q != 13'h0000) begin
      fl_cnt_q <= fl_cnt_q - 13'h0001;
    end
  end

  // A pump pulse still high at the next compare edge marks a cycle slip; a slip seen on
  // the edge that loses lock wins over the clear, or the boost would be missed.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      slip_q <= 1'b0;
    end else if (cmp_edge && (spacing_q == plc_pkg::SPACING_SAT ||
                              pin_q[plc_pkg::PIN_UP] || pin_q[plc_pkg::PIN_DN])) begin
      slip_q <= 1'b1;
    end else if (lock_q) begin
      slip_q <= 1'b0;
    end
  end

  // Calibrator clock enable: one tick per div_q compare edges, zero treated as one.
  always_ff @(posedge clk_sys) begin
    if (!rstn || cal_start) begin
      div_cnt_q <= 10'h000;
    end else if (cmp_edge) begin
      div_cnt_q <= cal_tick ? 10'h000 : div_cnt_q + 10'h001;
    end
  end
  assign cal_tick = cmp_edge && (div_cnt_q + 10'h001 >= div_q);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q;
    end
  end
  assign cal_start = (mst_wr && !(avs_byteenable[3] && avs_writedata[plc_pkg::INHIBIT_BIT])) ||
                     (recal_q && lock_prev_q && !lock_q);

  plc_vco_cal u_cal (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(cal_start),
    .cal_tick(cal_tick),
    .osc_too_fast(pin_q[plc_pkg::PIN_FAST]),
    .busy_q(cal_busy),
    .tune_hold_q(tune_hold),
    .osc_sel_q(osc_sel),
    .subband_q(subband)
  );

  // Registered analog controls.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lock_out <= 1'b0;
      pump_current_code <= 5'h00;
      wide_band_mode <= 1'b0;
      oscillator_amplitude <= plc_pkg::AMP_RST;
      primary_output_off <= 1'b1;
      secondary_output_off <= 1'b1;
    end else begin
      lock_out <= lock_q ^ pol_q;
      wide_band_mode <= (fl_cnt_q != 13'h0000);
      if (slip_q) begin
        pump_current_code <= plc_pkg::PUMP_MAX;
      end else if (fl_cnt_q != 13'h0000) begin
        pump_current_code <= fl_pump_q;
      end else begin
        pump_current_code <= pump_q;
      end
      oscillator_amplitude <= amp_q;
      primary_output_off <= pd1_q || pin_q[plc_pkg::PIN_PD1] || (mute_q && !lock_q);
      secondary_output_off <= pd2_q || pin_q[plc_pkg::PIN_PD2] || (mute_q && !lock_q);
    end
  end
endmodule
`default_nettype wire

// *** logic/plc_vco_cal.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_vco_cal (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Control.
  input wire logic start,
  input wire logic cal_tick,
  input wire logic osc_too_fast,
  // Result.
  output logic busy_q,
  output logic tune_hold_q,
  output logic [1:0] osc_sel_q,
  output logic [5:0] subband_q
);
  plc_pkg::plc_cal_state_t state_q;
  logic [3:0] step_q;
  logic [7:0] sar_q;
  logic [2:0] bit_q;

  // Successive approximation over oscillator and sub-band, one bit per tick.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= plc_pkg::CAL_IDLE;
      step_q <= 4'h0;
      sar_q <= 8'h00;
      bit_q <= 3'h7;
    end else if (start) begin
      state_q <= plc_pkg::CAL_PRECHARGE;
      step_q <= 4'h0;
      sar_q <= 8'h80;
      bit_q <= 3'h7;
    end else if (cal_tick) begin
      step_q <= step_q + 4'h1;
      case (state_q)
        plc_pkg::CAL_IDLE: begin
          step_q <= 4'h0;
        end
        plc_pkg::CAL_PRECHARGE: begin
          state_q <= plc_pkg::CAL_SEARCH;
        end
        plc_pkg::CAL_SEARCH: begin
          if (osc_too_fast) begin
            sar_q[bit_q] <= 1'b0;
          end
          if (bit_q == 3'h0) begin
            state_q <= plc_pkg::CAL_SETTLE;
          end else begin
            sar_q[bit_q - 3'h1] <= 1'b1;
            bit_q <= bit_q - 3'h1;
          end
        end
        plc_pkg::CAL_SETTLE: begin
          if (step_q == plc_pkg::CAL_STEPS - 4'h1) begin
            state_q <= plc_pkg::CAL_IDLE;
          end
        end
        default: begin
          state_q <= plc_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      tune_hold_q <= 1'b0;
      osc_sel_q <= 2'h0;
      subband_q <= 6'h00;
    end else begin
      busy_q <= start || (state_q != plc_pkg::CAL_IDLE);
      tune_hold_q <= start || (state_q == plc_pkg::CAL_PRECHARGE) ||
                     (state_q == plc_pkg::CAL_SEARCH);
      osc_sel_q <= sar_q[7:6];
      subband_q <= sar_q[5:0];
    end
  end
endmodule
`default_nettype wire

// *** test/plc_supervisor_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_supervisor_properties (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Register bus.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Pins and controls.
  input wire logic cmp_clk_pin,
  input wire logic primary_output_powerdown_pin,
  input wire logic secondary_output_powerdown_pin,
  input wire logic lock_out,
  input wire logic wide_band_mode,
  input wire logic [2:0] oscillator_amplitude,
  input wire logic tune_hold,
  input wire logic primary_output_off,
  input wire logic secondary_output_off
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  logic amp_wr;
  logic [2:0] amp_q;
  assign amp_wr = avs_write && !avs_waitrequest && avs_address == plc_pkg::LOCK_OFS
    && avs_byteenable[1:0] == 2'h3;
  // Keeps the amplitude of the last full write so the output can be judged two cycles on.
  always_ff @(posedge clk_sys) begin
    if (amp_wr) begin
      amp_q <= avs_writedata[9:7];
    end
  end
  rst_values_a:
    assert property (disable iff (1'h0) !rstn |=> avs_waitrequest && !lock_out && !tune_hold
      && !wide_band_mode && oscillator_amplitude == 3'h4 && primary_output_off
      && secondary_output_off) else $error("outputs differ from reset values");
  wait_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer lasted more than one cycle");
  wait_idle_a:
    assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without a request");
  pd_primary_a:
    assert property (primary_output_powerdown_pin [*8] |-> primary_output_off)
      else $error("primary output on while its pin asks power-down");
  pd_secondary_a:
    assert property (secondary_output_powerdown_pin [*8] |-> secondary_output_off)
      else $error("secondary output on while its pin asks power-down");
  lock_quiet_a:
    assert property ((!avs_write && $stable(cmp_clk_pin)) [*8] |=> $stable(lock_out))
      else $error("lock output moved without a compare edge");
  amp_follow_a:
    assert property (amp_wr |=> ##[1:2] oscillator_amplitude == amp_q)
      else $error("amplitude output does not follow its field");
  cover property ($rose(lock_out));
  cover property ($rose(tune_hold));
  cover property ($rose(wide_band_mode));
endmodule
bind plc_supervisor plc_supervisor_properties chk_i (.clk_sys(clk_sys), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .cmp_clk_pin(cmp_clk_pin),
  .primary_output_powerdown_pin(primary_output_powerdown_pin),
  .secondary_output_powerdown_pin(secondary_output_powerdown_pin), .lock_out(lock_out),
  .wide_band_mode(wide_band_mode), .oscillator_amplitude(oscillator_amplitude),
  .tune_hold(tune_hold), .primary_output_off(primary_output_off),
  .secondary_output_off(secondary_output_off));
`default_nettype wire

// *** test/plc_supervisor_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_supervisor_test;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cmp_clk_pin = 1'h0;
  logic pfd_up_pin = 1'h0;
  logic pfd_dn_pin = 1'h0;
  logic [4:0] pfd_edge_spacing = 5'h00;
  logic osc_too_fast_pin = 1'h0;
  logic pd1 = 1'h0;
  logic pd2 = 1'h0;
  logic lock_out, wide_band_mode, tune_hold, off1, off2;
  logic [4:0] pump;
  logic [2:0] amp;
  logic [1:0] osel;
  logic [5:0] sub;
  logic [31:0] rd_q;
  logic [31:0] m [4];
  logic [31:0] mk [4] = '{32'h03E1_FFFF, 32'h0000_1FFF, 32'h0000_07FF, 32'h0007_FFFF};
  int tg [7] = '{4, 8, 16, 32, 64, 256, 1024};
  int n_errors = 0;
  int cmp_count = 0;

  plc_supervisor dut (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_clk_pin(cmp_clk_pin),
    .pfd_up_pin(pfd_up_pin), .pfd_dn_pin(pfd_dn_pin), .pfd_edge_spacing(pfd_edge_spacing),
    .osc_too_fast_pin(osc_too_fast_pin), .primary_output_powerdown_pin(pd1),
    .secondary_output_powerdown_pin(pd2), .lock_out(lock_out), .pump_current_code(pump),
    .wide_band_mode(wide_band_mode), .oscillator_amplitude(amp), .tune_hold(tune_hold),
    .osc_sel(osel), .subband(sub), .primary_output_off(off1), .secondary_output_off(off2));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 100);
    if (k >= 100) begin
      n_errors++;
      end_sim();
    end
    rd_q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask

  // The model merges only enabled lanes and only bits that the register holds.
  task automatic wreg(input int a, input logic [31:0] d);
    logic [31:0] bm;
    bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
      {8{avs_byteenable[0]}}} & mk[a / 4 % 4];
    bus(1'h1, a[4:0], d);
    if (a < 16) m[a / 4] = (m[a / 4] & ~bm) | (d & bm);
  endtask

  task automatic rreg(input int a);
    bus(1'h0, a[4:0], 32'h0000_0000);
    chk("readdata", rd_q, a > 16 ? 32'h0000_0000 : (a == 0 ? m[0] | 32'h0400_0000 : m[a / 4]));
  endtask

  task automatic pulse(input logic [4:0] s, input logic [1:0] ud);
    pfd_edge_spacing <= s;
    {pfd_up_pin, pfd_dn_pin} <= ud;
    repeat (2) @(posedge clk_sys);
    cmp_clk_pin <= 1'h1;
    repeat (4) @(posedge clk_sys);
    cmp_clk_pin <= 1'h0;
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end

  initial begin
    int f;
    void'($urandom(50857));
    m = '{32'h0200_0000, 32'h0000_122E, 32'h0000_0001, 32'h0007_C000};
    repeat (3) @(posedge clk_sys);
    chk("lock_out", lock_out, 0);
    chk("outputs off", {off1, off2}, 2'h3);
    rstn <= 1'h1;
    repeat (4) @(posedge clk_sys);
    for (int a = 0; a < 24; a += 4) if (a != 16) rreg(a);
    for (int a = 0; a < 16; a += 4) wreg(a, $urandom() | (a == 0 ? 32'h0400_0000 : 0));
    wreg(16, $urandom());
    wreg(20, $urandom());
    avs_byteenable <= 4'h2;
    @(posedge clk_sys);
    wreg(4, $urandom());
    avs_byteenable <= 4'hF;
    for (int a = 0; a < 24; a += 4) if (a != 16) rreg(a);
    chk("amp", amp, m[1][9:7]);
    chk("pump", pump, m[0][25:21]);
    chk("lock_out", lock_out, m[1][0]);
    chk("tune_hold", tune_hold, 0);
    wreg(12, 0);
    wreg(8, 1);
    for (int c = 0; c < 7; c++) begin
      wreg(4, 32'h0000_100E | c << 4);
      pulse(5'h1F, 2'h0);
      repeat (tg[c] - 1) pulse(5'h00, 2'h0);
      chk("lock_out", lock_out, 0);
      pulse(5'h00, 2'h0);
      chk("lock_out", lock_out, 1);
    end
    for (int w = 0; w < 8; w++) begin
      wreg(4, 32'h0000_1000 | w << 1);
      pulse(5'h1F, 2'h0);
      repeat (4) pulse(5'(2 * w + 1), 2'h0);
      chk("lock_out", lock_out, 1);
      pulse(5'(2 * w + 2), 2'h0);
      chk("lock_out", lock_out, 0);
    end
    wreg(4, 32'h0000_1001);
    repeat (3) @(posedge clk_sys);
    chk("lock_out", lock_out, 1);
    repeat (4) pulse(5'h00, 2'h0);
    chk("lock_out", lock_out, 0);
    wreg(4, 32'h0000_100E);
    wreg(0, 32'h0520_0000);
    pulse(5'h1F, 2'h0);
    chk("pump", pump, 5'h1F);
    for (int u = 1; u < 3; u++) begin
      repeat (4) pulse(5'h00, 2'h0);
      chk("pump", pump, 5'h09);
      pulse(5'h14, 2'h0);
      pulse(5'h00, u[1:0]);
      chk("pump", pump, 5'h1F);
    end
    repeat (4) pulse(5'h00, 2'h0);
    wreg(12, 32'h0000_E005);
    wreg(0, 32'h0520_0000);
    repeat (3) @(posedge clk_sys);
    chk("pump", pump, 5'h03);
    repeat (4) pulse(5'h00, 2'h0);
    chk("wide", wide_band_mode, 1);
    pulse(5'h00, 2'h0);
    chk("wide", wide_band_mode, 0);
    chk("pump", pump, 5'h09);
    wreg(4, 32'h0000_140E);
    pulse(5'h1F, 2'h0);
    chk("off1", off1, 1);
    chk("tune_hold", tune_hold, 0);
    repeat (4) pulse(5'h00, 2'h0);
    chk("off1", off1, 0);
    pd1 <= 1'h1;
    repeat (8) @(posedge clk_sys);
    chk("off1", off1, 1);
    pd1 <= 1'h0;
    wreg(4, 32'h0000_080E);
    repeat (8) @(posedge clk_sys);
    chk("outputs off", {off1, off2}, 2'h2);
    pd2 <= 1'h1;
    repeat (8) @(posedge clk_sys);
    chk("off2", off2, 1);
    pd2 <= 1'h0;
    wreg(12, 0);
    for (int d = 1; d < 3; d++) begin
      f = $urandom_range(1, 0);
      osc_too_fast_pin <= f[0];
      wreg(8, d);
      wreg(0, 32'h0120_0000);
      repeat (8 * d) pulse(5'h00, 2'h0);
      chk("tune_hold", tune_hold, 1);
      bus(1'h0, 5'h10, 32'h0000_0000);
      chk("busy", rd_q[17:16], 2'h3);
      repeat (5 * d + 2) pulse(5'h00, 2'h0);
      chk("tune_hold", tune_hold, 0);
      chk("result", {osel, sub}, f ? 8'h00 : 8'hFF);
      bus(1'h0, 5'h10, 32'h0000_0000);
      chk("status", rd_q, {16'h0000, (f ? 8'h00 : 8'hFF), 2'h0, 5'h09, 1'h1});
    end
    // Final dividers go in with the search held off, so the chosen band must stay.
    wreg(0, 32'h0520_0200);
    repeat (3) pulse(5'h00, 2'h0);
    chk("tune_hold", tune_hold, 0);
    chk("result", {osel, sub}, f ? 8'h00 : 8'hFF);
    wreg(8, 32'h0000_0401);
    pulse(5'h1F, 2'h0);
    pulse(5'h00, 2'h0);
    chk("tune_hold", tune_hold, 1);
    end_sim();
  end
endmodule
`default_nettype wire
